/* File: shared/xid_pkg.sv */
// package of constants and carrier types for the exclusive-or datapath
// Contract
// - literal form: acc xor low byte into acc
// - literal spans 0..255 in low eight bits
// - file form: acc xor addressed file register
// - file address is seven low bits, 0..127
// - dest bit 0 to acc, 1 to file
// - only zero flag changes, others kept
// - one word, four phases: decode read process write
package xid_pkg;
  // ****************************************
  // instruction word layout
  // ****************************************
  localparam int          XID_IW_W        = 14;
  localparam logic [5:0]  XID_OP_LIT      = 6'h3a;  // 11 1010
  localparam logic [5:0]  XID_OP_FILE     = 6'h06;  // 00 0110
  localparam int          XID_OP_MSB      = 13;
  localparam int          XID_OP_LSB      = 8;
  localparam int          XID_DEST_BIT    = 7;
  localparam int          XID_ADDR_MSB    = 6;
  localparam int          XID_STATUS_W    = 8;
  localparam int          XID_ZERO_BIT    = 2;
  localparam logic [7:0]  XID_ACC_RST     = 8'h00;
  localparam logic [7:0]  XID_STATUS_RST  = 8'h00;
  localparam logic [6:0]  XID_ADDR_RST    = 7'h00;

  // four-phase cycle, one-hot
  typedef enum logic [3:0] {
    XID_PH_DECODE  = 4'h1,
    XID_PH_READ    = 4'h2,
    XID_PH_PROCESS = 4'h4,
    XID_PH_WRITE   = 4'h8
  } xid_phase_e;

  // file register write carrier
  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } xid_fwr_s;
endpackage

/* File: verilog/xid_datapath.sv */
// exclusive-or datapath running the four-phase instruction cycle
`timescale 1ns/100ps
module xid_datapath
  import xid_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // instruction in, sampled in decode phase
  input  wire logic [XID_IW_W-1:0]     instr,
  // file register read data, valid in read phase
  input  wire logic [7:0]              file_rdata,
  // file register access
  output logic      [6:0]              file_raddr,
  output xid_fwr_s                     file_wr,
  // architectural state
  output logic      [7:0]              acc,
  output logic      [XID_STATUS_W-1:0] status,
  output xid_phase_e                   phase,
  output logic                         done
);
  // ****************************************
  // state
  // ****************************************
  xid_phase_e              phase_reg, phase_next;
  logic [XID_IW_W-1:0]     ir_reg;
  logic [7:0]              opnd_reg, res_reg, acc_reg;
  logic [XID_STATUS_W-1:0] status_reg;
  logic [6:0]              raddr_reg;
  xid_fwr_s                fwr_reg;
  logic                    done_reg;
  logic                    is_lit, is_file, dest_file;

  // decode from the latched word, so a later change on instr cannot
  // retarget a write that is already in flight
  assign is_lit    = (ir_reg[XID_OP_MSB:XID_OP_LSB] == XID_OP_LIT);
  assign is_file   = (ir_reg[XID_OP_MSB:XID_OP_LSB] == XID_OP_FILE);
  assign dest_file = ir_reg[XID_DEST_BIT];

  // phase sequencer, one instruction per four clocks
  always_comb begin
    case (phase_reg)
      XID_PH_DECODE:  phase_next = XID_PH_READ;
      XID_PH_READ:    phase_next = XID_PH_PROCESS;
      XID_PH_PROCESS: phase_next = XID_PH_WRITE;
      XID_PH_WRITE:   phase_next = XID_PH_DECODE;
      default:        phase_next = XID_PH_DECODE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) phase_reg <= XID_PH_DECODE;
    else        phase_reg <= phase_next;
  end

  // ****************************************
  // decode and read
  // ****************************************
  // latch word and present file address during decode
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ir_reg    <= '0;
      raddr_reg <= XID_ADDR_RST;
    end else if (phase_reg == XID_PH_DECODE) begin
      ir_reg    <= instr;
      raddr_reg <= instr[XID_ADDR_MSB:0];
    end
  end

  // operand: low byte literal or file data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) opnd_reg <= 8'h00;
    else if (phase_reg == XID_PH_READ)
      opnd_reg <= is_lit ? ir_reg[7:0] : file_rdata;
  end

  // ****************************************
  // process and write
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) res_reg <= 8'h00;
    else if (phase_reg == XID_PH_PROCESS)
      res_reg <= acc_reg ^ opnd_reg;
  end

  // accumulator write; file destination leaves it alone
  // foreign opcodes fall through the ring: no write, no flag
  always_ff @(posedge sys_clk) begin
    if (!rst_n) acc_reg <= XID_ACC_RST;
    else if (phase_reg == XID_PH_WRITE && (is_lit || (is_file && !dest_file)))
      acc_reg <= res_reg;
  end

  // file write strobe, one cycle after write phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) fwr_reg <= '0;
    else begin
      fwr_reg.en   <= (phase_reg == XID_PH_WRITE) && is_file && dest_file;
      fwr_reg.addr <= raddr_reg;
      fwr_reg.data <= res_reg;
    end
  end

  // zero flag only; other status bits held
  // the remaining bits belong to other units, written here only by reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) status_reg <= XID_STATUS_RST;
    else if (phase_reg == XID_PH_WRITE && (is_lit || is_file))
      status_reg[XID_ZERO_BIT] <= (res_reg == 8'h00);
  end

  // completion pulse on cycle boundary
  always_ff @(posedge sys_clk) begin
    if (!rst_n) done_reg <= 1'b0;
    else        done_reg <= (phase_reg == XID_PH_WRITE);
  end

  assign phase      = phase_reg;
  assign acc        = acc_reg;
  assign status     = status_reg;
  assign file_raddr = raddr_reg;
  assign file_wr    = fwr_reg;
  assign done       = done_reg;

  // ****************************************
  // checks
  // ****************************************
  // every check runs on the core clock; reset masks the ones in flight
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // sequencer: exactly one phase at a time, none skipped
  a_phase_onehot: assert property (
    $onehot(phase_reg))
    else $error("phase not one-hot");

  a_phase_ring: assert property (
    phase_reg == XID_PH_DECODE |=> phase_reg == XID_PH_READ
    ##1 phase_reg == XID_PH_PROCESS ##1 phase_reg == XID_PH_WRITE
    ##1 phase_reg == XID_PH_DECODE)
    else $error("phase ring broken");

  // word and address are taken once, in decode; the bus is free afterwards
  a_file_addr: assert property (
    phase_reg == XID_PH_DECODE
    |=> raddr_reg == $past(instr[XID_ADDR_MSB:0]))
    else $error("file address wrong");

  a_word_held: assert property (
    phase_reg != XID_PH_DECODE
    |=> ir_reg == $past(ir_reg) && raddr_reg == $past(raddr_reg))
    else $error("word moved outside decode");

  // operand picked in read: literal byte or file data
  a_lit_operand: assert property (
    phase_reg == XID_PH_READ && is_lit
    |=> opnd_reg == $past(ir_reg[7:0]))
    else $error("literal operand wrong");

  a_file_operand: assert property (
    phase_reg == XID_PH_READ && is_file
    |=> opnd_reg == $past(file_rdata))
    else $error("file operand wrong");

  // result held through write is the xor of the live operands
  a_result_xor: assert property (
    phase_reg == XID_PH_WRITE
    |-> res_reg == (acc_reg ^ opnd_reg))
    else $error("result not acc xor operand");

  // destination steering at the end of write
  a_lit_result: assert property (
    phase_reg == XID_PH_WRITE && is_lit
    |=> acc_reg == $past(res_reg) && !fwr_reg.en)
    else $error("literal result not in acc");

  a_file_acc: assert property (
    phase_reg == XID_PH_WRITE && is_file && !dest_file
    |=> acc_reg == $past(res_reg) && !fwr_reg.en)
    else $error("file result not in acc");

  a_dest_file: assert property (
    phase_reg == XID_PH_WRITE && is_file && dest_file
    |=> fwr_reg.en && acc_reg == $past(acc_reg))
    else $error("file dest wrong");

  a_file_data: assert property (
    phase_reg == XID_PH_WRITE && is_file && dest_file
    |=> fwr_reg.addr == $past(raddr_reg) && fwr_reg.data == $past(res_reg))
    else $error("file write payload wrong");

  // foreign opcodes pass through the ring without touching state
  a_foreign_idle: assert property (
    phase_reg == XID_PH_WRITE && !is_lit && !is_file
    |=> acc_reg == $past(acc_reg) && status_reg == $past(status_reg) && !fwr_reg.en)
    else $error("foreign opcode changed state");

  // flags: zero only, and only at the end of write
  a_other_flags: assert property (
    $changed(status_reg)
    |-> (status_reg ^ $past(status_reg)) == (8'h01 << XID_ZERO_BIT))
    else $error("other flag moved");

  a_zero_flag: assert property (
    phase_reg == XID_PH_WRITE && (is_lit || is_file)
    |=> status_reg[XID_ZERO_BIT] == ($past(res_reg) == 8'h00))
    else $error("zero flag wrong");

  a_state_quiet: assert property (
    phase_reg != XID_PH_WRITE
    |=> $stable(acc_reg) && $stable(status_reg))
    else $error("state moved outside write");

  // completion and file strobes stand for one clock only
  a_done_set: assert property (
    phase_reg == XID_PH_WRITE |=> done_reg)
    else $error("done pulse missing");

  a_strobe_clear: assert property (
    phase_reg != XID_PH_WRITE |=> !done_reg && !fwr_reg.en)
    else $error("strobe outside write");

  // main scenarios
  c_lit: cover property (phase_reg == XID_PH_WRITE && is_lit);
  c_file_acc: cover property (phase_reg == XID_PH_WRITE && is_file && !dest_file);
  c_file_file: cover property (phase_reg == XID_PH_WRITE && is_file && dest_file);
  c_zero: cover property (phase_reg == XID_PH_WRITE && is_lit && res_reg == 8'h00);
  c_foreign: cover property (phase_reg == XID_PH_WRITE && !is_lit && !is_file);
endmodule // xid_datapath

/* File: tb/xid_datapath_test.sv */
// self-checking bench for the exclusive-or datapath
`timescale 1ns/100ps
module xid_datapath_test;
  import xid_pkg::*;
  logic        sys_clk    = 1'b0;
  logic        rst_n      = 1'b0;
  logic [13:0] instr      = 14'h0000;
  logic [7:0]  file_rdata = 8'h00;
  logic [6:0]  file_raddr;
  xid_fwr_s    file_wr;
  logic [7:0]  acc;
  logic [7:0]  status;
  xid_phase_e  phase;
  logic        done;
  logic [31:0] seed       = 32'h7b5cca9e;
  logic [7:0]  exp_acc    = 8'h00;
  logic        exp_z      = 1'b0;
  int          fails      = 0;
  int          checks     = 0;

  // ************
  // clock and dut
  // ************
  always #5 sys_clk = ~sys_clk;

  xid_datapath dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .instr(instr),
    .file_rdata(file_rdata), .file_raddr(file_raddr), .file_wr(file_wr),
    .acc(acc), .status(status), .phase(phase), .done(done));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  // expected xor result of one word against the accumulator model
  function automatic logic [7:0] xor_model(input logic [7:0] a, input logic [13:0] iw,
                                           input logic [7:0] rd);
    return a ^ ((iw[XID_OP_MSB:XID_OP_LSB] == XID_OP_LIT) ? iw[7:0] : rd);
  endfunction

  // state straight after a reset release, from the package reset values
  task automatic chk_reset(input string msg);
    chk({acc, status, phase} === {XID_ACC_RST, XID_STATUS_RST, XID_PH_DECODE}, msg);
    chk({file_wr, done, file_raddr} === {16'h0000, 1'b0, XID_ADDR_RST}, msg);
  endtask

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic wrap_up;
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one instruction, four edges; rdata held the whole cycle, not only in read
  task automatic run(input logic [13:0] iw, input logic [7:0] rd);
    logic [7:0] res;
    logic       lit, fil;
    int         n;
    n = 0;
    while (phase !== XID_PH_DECODE && n < 8) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n == 8) begin
      chk(1'b0, "phase ring stuck");
      return;
    end
    lit = iw[13:8] == XID_OP_LIT;
    fil = iw[13:8] == XID_OP_FILE;
    res = xor_model(exp_acc, iw, rd);
    instr = iw;
    file_rdata = rd;
    @(posedge sys_clk);
    #1 if (fil) chk(file_raddr === iw[6:0], "file address");
    chk(phase === XID_PH_READ, "phase after decode");
    chk({done, file_wr.en} === 2'b00, "strobe longer than a cycle");
    repeat (3) @(posedge sys_clk);
    #1 if (lit || (fil && !iw[7])) exp_acc = res;
    if (lit || fil) exp_z = res == 8'h00;
    chk(acc === exp_acc, "acc value");
    chk(status === {5'h00, exp_z, 2'h0}, "status flags");
    chk(file_wr.en === (fil && iw[7]), "file strobe");
    if (fil && iw[7]) chk({file_wr.addr, file_wr.data} === {iw[6:0], res}, "file wr");
    chk(done === 1'b1, "done pulse");
  endtask

  // ************
  // main sequence
  // ************
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    chk_reset("reset state");
    run({XID_OP_LIT, 8'hb5}, 8'h00);
    run({XID_OP_LIT, 8'hb5}, 8'h00);
    run({XID_OP_LIT, 8'hff}, 8'h00);
    run({XID_OP_FILE, 8'h7f}, 8'haf);
    run({XID_OP_FILE, 8'h80}, 8'h00);
    run({XID_OP_FILE, 8'hff}, 8'h00);
    run({6'h0e, 8'hff}, 8'h5a);
    // reset in mid-run clears state and restarts the ring in decode
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    exp_acc = XID_ACC_RST;
    exp_z   = 1'b0;
    chk_reset("mid-run reset");
    run({XID_OP_LIT, 8'hb5}, 8'h00);
    run({XID_OP_LIT, 8'haf}, 8'h00);
    // random mix; a quarter of the opcodes are drawn freely
    for (int i = 0; i < 300; i++) begin
      seed = lfsr(seed);
      run({seed[1:0] == 2'h0 ? seed[29:24] : (seed[0] ? XID_OP_LIT : XID_OP_FILE),
           seed[15:8]}, seed[23:16]);
    end
    wrap_up();
  end
endmodule // xid_datapath_test
